// ===== src/srm_spi_dev.sv
// Serial register port, mode-driven block enables, pin functions, rx FIFO
// Behaviour
// - Frame is sixteen bits: direction, seven address bits, eight data bits.
// - Direction one writes a register, direction zero reads it.
// - Seven-bit address selects one of 128 byte registers.
// - Address and data are captured whole, every eight serial clocks.
// - During a read, input on the data byte is ignored.
// - Read data leaves on the next eight falling serial clock edges.
// - After a read byte, output keeps the last bit until deselect.
// - While deselected, output is released to the pull-up, not driven.
// - Continued clocking under select steps the address for the next byte.
// - In bursts, a new input byte is latched every eight clocks.
// - Every mode but shutdown is chosen by register write.
// - Block enables accumulate from standby up to receive.
// - Don't-care blocks follow independent option bits.
// - Low-frequency oscillator and wake timer switch as one group.
// - Auxiliary group enable follows the mode mapping.
// - Port and register storage stay on in every powered mode.
// - Received bytes are read from a 64-byte FIFO or a pin.
// - Three pins offer clock, antenna, reset and interrupt functions.
// - After reset or power-down the ready mode is selected.
`timescale 1ns/1ps
`default_nettype none
module srm_spi_dev
    import srm_pkg::*;
#(
    parameter int POR_CYC = POR_CYCLES
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Serial port pins
    input wire logic spi_sclk,
    input wire logic spi_sdi,
    input wire logic chip_select_n,
    output logic spi_sdo,
    output logic spi_sdo_oe,
    // Power control pin
    input wire logic power_down_pin,
    // Demodulator side
    input wire logic [FIFO_W-1:0] rx_byte,
    input wire logic rx_byte_valid,
    output logic rx_byte_ready,
    input wire logic rx_bit,
    input wire logic irq_n_in,
    input wire logic ant_sel,
    // Pin functions
    output logic [GPIO_N-1:0] gpio_out,
    output logic [GPIO_N-1:0] gpio_oe,
    // Block enables
    output logic [EN_W-1:0] blk_en,
    output srm_mode_t mode
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic cs_m, cs_s, ck_m, ck_s, ck_d, di_m, di_s, pd_m, pd_s;
        logic [BIT_CNT_W-1:0] cnt;
        logic data_ph;
        logic is_wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-2:0] sh;
        logic [DATA_W-1:0] tx;
        logic sdo;
        logic sdo_oe;
        logic pop;
        logic [NUM_REGS-1:0][DATA_W-1:0] regs;
        logic [DATA_W-1:0] mode_reg;
        logic [DATA_W-1:0] opt_reg;
        logic [GPIO_N-1:0][GPIO_FN_W-1:0] gcfg;
        logic [EN_W-1:0] en;
        logic [MCLK_CNT_W-1:0] mcnt;
        logic mclk;
        logic [POR_CNT_W-1:0] por_cnt;
        logic por_busy;
        logic [GPIO_N-1:0] go;
        logic [GPIO_N-1:0] goe;
    } srm_st_t;

    localparam logic [POR_CNT_W-1:0] POR_LAST = POR_CNT_W'(POR_CYC - 1);
    localparam logic [MCLK_CNT_W-1:0] MCLK_LAST = MCLK_CNT_W'(MCLK_HALF - 1);

    srm_st_t st_r;
    srm_st_t st_nxt;
    logic rise;
    logic fall;
    logic byte_done;
    logic [DATA_W-1:0] byte_in;
    logic [FIFO_W-1:0] fifo_data;
    logic fifo_valid;
    srm_mode_t mode_cur;

    // ------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------

    // Set mode bit wins in order receive, tune, ready, sensor, sleep; no encoding reaches shutdown
    function automatic srm_mode_t mode_of(input logic [DATA_W-1:0] m);
        srm_mode_t r;
        r = MODE_STANDBY;
        if (m[MB_RX]) begin
            r = MODE_RX;
        end else if (m[MB_TUNE]) begin
            r = MODE_TUNE;
        end else if (m[MB_READY]) begin
            r = MODE_READY;
        end else if (m[MB_SENSOR]) begin
            r = MODE_SENSOR;
        end else if (m[MB_SLEEP]) begin
            r = MODE_SLEEP;
        end
        return r;
    endfunction

    // Read value of one register address
    function automatic logic [DATA_W-1:0] rd_val(input srm_st_t s,
            input logic [ADDR_W-1:0] a, input logic fv,
            input logic [FIFO_W-1:0] fd);
        logic [DATA_W-1:0] r;
        r = s.regs[a];
        case (a)
            REG_STATUS: r = {fv, 4'h0, mode_of(s.mode_reg)};
            REG_MODE: r = s.mode_reg;
            REG_OPT: r = s.opt_reg;
            REG_GPIO0: r = {5'h00, s.gcfg[0]};
            REG_GPIO1: r = {5'h00, s.gcfg[1]};
            REG_GPIO2: r = {5'h00, s.gcfg[2]};
            REG_FIFO: r = fv ? fd : 8'h00;
            default: r = s.regs[a];
        endcase
        return r;
    endfunction

    // ------------------------------------------------------------------
    // Receive FIFO
    // ------------------------------------------------------------------
    srm_fifo #(
        .W(FIFO_W),
        .DEPTH(FIFO_DEPTH),
        .PTR_W(FIFO_PTR_W)
    ) u_rx_fifo (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .in_data(rx_byte),
        .in_valid(rx_byte_valid),
        .in_ready(rx_byte_ready),
        .out_data(fifo_data),
        .out_valid(fifo_valid),
        .out_ready(st_r.pop)
    );

    // Edge finding on the synchronised serial clock
    assign rise = st_r.ck_s & ~st_r.ck_d;
    assign fall = ~st_r.ck_s & st_r.ck_d;
    assign byte_in = {st_r.sh, st_r.di_s};
    assign byte_done = rise & (st_r.cnt == BIT_LAST) & ~st_r.cs_s;
    assign mode_cur = mode_of(st_r.mode_reg);

    // Outputs
    assign spi_sdo = st_r.sdo;
    assign spi_sdo_oe = st_r.sdo_oe;
    assign gpio_out = st_r.go;
    assign gpio_oe = st_r.goe;
    assign blk_en = st_r.en;
    assign mode = mode_cur;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.pop = 1'b0;
        // Two-stage synchronisers for every pin input
        st_nxt.cs_m = chip_select_n;
        st_nxt.cs_s = st_r.cs_m;
        st_nxt.ck_m = spi_sclk;
        st_nxt.ck_s = st_r.ck_m;
        st_nxt.ck_d = st_r.ck_s;
        st_nxt.di_m = spi_sdi;
        st_nxt.di_s = st_r.di_m;
        st_nxt.pd_m = power_down_pin;
        st_nxt.pd_s = st_r.pd_m;

        if (st_r.pd_s) begin
            // Shutdown: port dead, registers lost, ready mode on exit
            st_nxt.cnt = '0;
            st_nxt.data_ph = 1'b0;
            st_nxt.sdo = 1'b1;
            st_nxt.sdo_oe = 1'b0;
            st_nxt.regs = '0;
            st_nxt.mode_reg = MODE_RESET;
            st_nxt.opt_reg = OPT_RESET;
            st_nxt.gcfg = '0;
            st_nxt.por_cnt = '0;
            st_nxt.por_busy = 1'b1;
        end else if (st_r.cs_s) begin
            // Deselected: drop partial byte, release output
            st_nxt.cnt = '0;
            st_nxt.data_ph = 1'b0;
            st_nxt.sdo = 1'b1;
            st_nxt.sdo_oe = 1'b0;
        end else begin
            // Rising edge: shift in, MSB first
            if (rise) begin
                st_nxt.sh = byte_in[DATA_W-2:0];
                st_nxt.cnt = st_r.cnt + 1'b1;
            end
            if (byte_done && !st_r.data_ph) begin
                // Address byte complete
                st_nxt.data_ph = 1'b1;
                st_nxt.is_wr = byte_in[DIR_BIT];
                st_nxt.addr = byte_in[ADDR_W-1:0];
                if (!byte_in[DIR_BIT]) begin
                    st_nxt.tx = rd_val(st_r, byte_in[ADDR_W-1:0],
                        fifo_valid, fifo_data);
                    st_nxt.pop = (byte_in[ADDR_W-1:0] == REG_FIFO) &
                        fifo_valid;
                end
            end else if (byte_done) begin
                // Data byte complete: store, then step the address
                if (st_r.is_wr) begin
                    case (st_r.addr)
                        REG_MODE: st_nxt.mode_reg = byte_in;
                        REG_OPT: st_nxt.opt_reg = byte_in;
                        REG_GPIO0: st_nxt.gcfg[0] = byte_in[GPIO_FN_W-1:0];
                        REG_GPIO1: st_nxt.gcfg[1] = byte_in[GPIO_FN_W-1:0];
                        REG_GPIO2: st_nxt.gcfg[2] = byte_in[GPIO_FN_W-1:0];
                        REG_STATUS, REG_FIFO: st_nxt.regs = st_r.regs;
                        default: st_nxt.regs[st_r.addr] = byte_in;
                    endcase
                end else begin
                    // Read: input byte ignored, next register loaded
                    st_nxt.tx = rd_val(st_r, st_r.addr + ADDR_STEP,
                        fifo_valid, fifo_data);
                    st_nxt.pop = ((st_r.addr + ADDR_STEP) == REG_FIFO) &
                        fifo_valid;
                end
                st_nxt.addr = st_r.addr + ADDR_STEP;
            end
            // Falling edge: next read bit out; holds between edges
            if (fall && st_r.data_ph && !st_r.is_wr) begin
                st_nxt.sdo = st_r.tx[DATA_W-1];
                st_nxt.tx = {st_r.tx[DATA_W-2:0], 1'b0};
                st_nxt.sdo_oe = 1'b1;
            end
        end

        // Block enables by mode, option bits for don't-care cells
        st_nxt.en = '0;
        st_nxt.en[EN_LDO] = ~st_r.pd_s;
        st_nxt.en[EN_SPI] = ~st_r.pd_s;
        if (!st_r.pd_s) begin
            case (mode_cur)
                MODE_STANDBY: st_nxt.en[EN_LFOSC] = 1'b0;
                MODE_SLEEP: begin
                    st_nxt.en[EN_LFOSC] = 1'b1;
                    st_nxt.en[EN_AUX] = st_r.opt_reg[OPT_AUX];
                end
                MODE_SENSOR: begin
                    st_nxt.en[EN_LFOSC] = st_r.opt_reg[OPT_LFOSC];
                    st_nxt.en[EN_AUX] = 1'b1;
                end
                default: begin
                    st_nxt.en[EN_LFOSC] = st_r.opt_reg[OPT_LFOSC];
                    st_nxt.en[EN_AUX] = st_r.opt_reg[OPT_AUX];
                    st_nxt.en[EN_MAIN_CRYSTAL_OSC] = 1'b1;
                    st_nxt.en[EN_PLL] = (mode_cur == MODE_TUNE) ||
                        (mode_cur == MODE_RX);
                    st_nxt.en[EN_RX] = (mode_cur == MODE_RX);
                end
            endcase
        end

        // Host clock divider
        if (st_r.mcnt == MCLK_LAST) begin
            st_nxt.mcnt = '0;
            st_nxt.mclk = ~st_r.mclk;
        end else begin
            st_nxt.mcnt = st_r.mcnt + 1'b1;
        end

        // Reset indication window after power-up or power-down exit
        if (!st_r.pd_s && st_r.por_busy) begin
            st_nxt.por_cnt = st_r.por_cnt + 1'b1;
            st_nxt.por_busy = (st_r.por_cnt != POR_LAST);
        end

        // Pin function select
        for (int i = 0; i < GPIO_N; i++) begin
            st_nxt.goe[i] = (st_r.gcfg[i] != GF_OFF) & ~st_r.pd_s;
            case (st_r.gcfg[i])
                GF_MCLK: st_nxt.go[i] = st_r.mclk;
                GF_ANT: st_nxt.go[i] = ant_sel;
                GF_ANT_N: st_nxt.go[i] = ~ant_sel;
                GF_POR: st_nxt.go[i] = st_r.por_busy;
                GF_IRQ: st_nxt.go[i] = irq_n_in;
                GF_RXBIT: st_nxt.go[i] = rx_bit;
                GF_FIFO_NE: st_nxt.go[i] = fifo_valid;
                default: st_nxt.go[i] = 1'b0;
            endcase
        end
    end

    // State register
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st_r <= '0;
            st_r.cs_m <= 1'b1;
            st_r.cs_s <= 1'b1;
            st_r.sdo <= 1'b1;
            st_r.mode_reg <= MODE_RESET;
            st_r.opt_reg <= OPT_RESET;
            st_r.por_busy <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence s_addr_done;
        byte_done && !st_r.data_ph && !st_r.pd_s;
    endsequence

    sequence s_data_done;
        byte_done && st_r.data_ph && !st_r.pd_s;
    endsequence

    property p_deselect_release;
        @(posedge sys_clk) disable iff (!nrst)
        st_r.cs_s |=> !spi_sdo_oe && spi_sdo && st_r.cnt == 3'h0;
    endproperty
    a_deselect_release: assert property (p_deselect_release)
        else $error("output driven or count kept while deselected");

    property p_addr_capture;
        @(posedge sys_clk) disable iff (!nrst)
        s_addr_done |=> st_r.data_ph && st_r.is_wr == $past(byte_in[7])
            && st_r.addr == $past(byte_in[6:0]);
    endproperty
    a_addr_capture: assert property (p_addr_capture)
        else $error("address byte not captured whole");

    property p_burst_step;
        @(posedge sys_clk) disable iff (!nrst)
        s_data_done |=> st_r.addr == $past(st_r.addr) + ADDR_STEP;
    endproperty
    a_burst_step: assert property (p_burst_step)
        else $error("address did not step after data byte");

    property p_write_store;
        @(posedge sys_clk) disable iff (!nrst)
        s_data_done ##0 (st_r.is_wr && st_r.addr > REG_GPIO2 &&
            st_r.addr != REG_FIFO) |=>
            st_r.regs[$past(st_r.addr)] == $past(byte_in);
    endproperty
    a_write_store: assert property (p_write_store)
        else $error("written byte not stored");

    property p_read_shift;
        @(posedge sys_clk) disable iff (!nrst)
        fall && st_r.data_ph && !st_r.is_wr && !st_r.cs_s && !st_r.pd_s
            |=> spi_sdo_oe && spi_sdo == $past(st_r.tx[7]);
    endproperty
    a_read_shift: assert property (p_read_shift)
        else $error("read bit not presented on falling edge");

    property p_read_hold;
        @(posedge sys_clk) disable iff (!nrst)
        !fall && !st_r.cs_s && !st_r.pd_s |=> $stable(spi_sdo);
    endproperty
    a_read_hold: assert property (p_read_hold)
        else $error("output moved without a falling edge");

    property p_read_ignores_in;
        @(posedge sys_clk) disable iff (!nrst)
        s_data_done ##0 !st_r.is_wr |=> $stable(st_r.regs) &&
            $stable(st_r.mode_reg) && $stable(st_r.opt_reg);
    endproperty
    a_read_ignores_in: assert property (p_read_ignores_in)
        else $error("read frame altered a register");

    property p_mode_chain;
        @(posedge sys_clk) disable iff (!nrst)
        blk_en[EN_RX] |-> blk_en[EN_PLL] && blk_en[EN_MAIN_CRYSTAL_OSC] &&
            blk_en[EN_SPI] && blk_en[EN_LDO];
    endproperty
    a_mode_chain: assert property (p_mode_chain)
        else $error("receive enabled without lower blocks");

    property p_shutdown_ready;
        @(posedge sys_clk) disable iff (!nrst)
        st_r.pd_s |=> mode == MODE_READY ##1 (blk_en[EN_SPI] == 1'b0
            || !st_r.pd_s);
    endproperty
    a_shutdown_ready: assert property (p_shutdown_ready)
        else $error("power-down did not restore ready mode");

endmodule
`default_nettype wire

// ===== src/srm_pkg.sv
// Constants and types shared by the serial register port and its FIFO
package srm_pkg;

    // ------------------------------------------------------------------
    // Frame layout
    // ------------------------------------------------------------------
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam int BIT_CNT_W = 3;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam int DIR_BIT = 7;
    localparam logic [6:0] ADDR_STEP = 7'h01;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [6:0] REG_STATUS = 7'h02;
    localparam logic [6:0] REG_MODE = 7'h07;
    localparam logic [6:0] REG_OPT = 7'h08;
    localparam logic [6:0] REG_GPIO0 = 7'h0B;
    localparam logic [6:0] REG_GPIO1 = 7'h0C;
    localparam logic [6:0] REG_GPIO2 = 7'h0D;
    localparam logic [6:0] REG_FIFO = 7'h7F;
    localparam int NUM_REGS = 128;

    // ------------------------------------------------------------------
    // Mode register bits, option bits, reset values
    // ------------------------------------------------------------------
    localparam int MB_READY = 0;
    localparam int MB_TUNE = 1;
    localparam int MB_RX = 2;
    localparam int MB_SENSOR = 3;
    localparam int MB_SLEEP = 4;
    localparam logic [7:0] MODE_RESET = 8'h01;
    localparam int OPT_LFOSC = 0;
    localparam int OPT_AUX = 1;
    localparam logic [7:0] OPT_RESET = 8'h00;

    // Block enable vector positions
    localparam int EN_LDO = 0;
    localparam int EN_SPI = 1;
    localparam int EN_LFOSC = 2;
    localparam int EN_AUX = 3;
    localparam int EN_MAIN_CRYSTAL_OSC = 4;
    localparam int EN_PLL = 5;
    localparam int EN_RX = 6;
    localparam int EN_W = 7;

    // ------------------------------------------------------------------
    // FIFO and pins
    // ------------------------------------------------------------------
    localparam int FIFO_W = 8;
    localparam int FIFO_DEPTH = 64;
    localparam int FIFO_PTR_W = 6;
    localparam int GPIO_N = 3;
    localparam int GPIO_FN_W = 3;
    localparam logic [2:0] GF_OFF = 3'h0;
    localparam logic [2:0] GF_MCLK = 3'h1;
    localparam logic [2:0] GF_ANT = 3'h2;
    localparam logic [2:0] GF_ANT_N = 3'h3;
    localparam logic [2:0] GF_POR = 3'h4;
    localparam logic [2:0] GF_IRQ = 3'h5;
    localparam logic [2:0] GF_RXBIT = 3'h6;
    localparam logic [2:0] GF_FIFO_NE = 3'h7;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int SYS_CLK_HZ = 10_000_000;
    localparam int MCLK_HZ = 1_000_000;
    localparam int MCLK_HALF = SYS_CLK_HZ / (2 * MCLK_HZ);
    localparam int MCLK_CNT_W = 3;
    localparam int POR_TIME_MS = 16;
    localparam int POR_CYCLES = (SYS_CLK_HZ / 1000) * POR_TIME_MS;
    localparam int POR_CNT_W = 18;

    // Idle and receive modes, lowest power first
    typedef enum logic [2:0] {
        MODE_STANDBY,
        MODE_SLEEP,
        MODE_SENSOR,
        MODE_READY,
        MODE_TUNE,
        MODE_RX
    } srm_mode_t;

endpackage

// ===== src/srm_fifo.sv
// Receive byte FIFO with registered read data
`timescale 1ns/1ps
`default_nettype none
module srm_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 64,
    parameter int PTR_W = 6
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Fill side
    input wire logic [W-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    // Drain side
    output logic [W-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PTR_W-1:0] wr;
        logic [PTR_W-1:0] rd;
        logic [PTR_W:0] cnt;
        logic [W-1:0] dout;
        logic vld;
    } srm_fifo_st_t;

    srm_fifo_st_t st_r;
    srm_fifo_st_t st_nxt;
    logic push;
    logic pop;

    // Full from the live count; valid from the registered head flag
    assign in_ready = (st_r.cnt != (PTR_W+1)'(DEPTH));
    assign out_valid = st_r.vld;
    assign out_data = st_r.dout;
    assign push = in_valid & in_ready;
    assign pop = out_ready & st_r.vld;

    // Pointer, count and head register update
    always_comb begin
        st_nxt = st_r;
        if (push) begin
            st_nxt.mem[st_r.wr] = in_data;
            st_nxt.wr = st_r.wr + 1'b1;
        end
        if (pop) begin
            st_nxt.rd = st_r.rd + 1'b1;
        end
        st_nxt.cnt = st_r.cnt + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
        st_nxt.dout = st_r.mem[st_r.rd];
        st_nxt.vld = (st_r.cnt != '0) & ~pop;
    end

    // State register
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

endmodule
`default_nettype wire

// ===== testbench/srm_host.sv
// Host-side serial master model for the register port
`timescale 1ns/1ps
`default_nettype none
module srm_host (
    // Serial lines
    output logic sclk,
    output logic sdi,
    output logic cs_n,
    input wire logic sdo_line
);
    // Idle: deselected, clock parked low
    initial begin
        sclk = 1'b0;
        sdi = 1'b0;
        cs_n = 1'b1;
    end

    // Select with setup time before the first bit
    task automatic open_frame();
        cs_n = 1'b0;
        #400;
    endtask

    // MSB first, change on fall, sample return before the next fall
    task automatic shift(input logic [7:0] tx, input int n,
                         output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - n; i--) begin
            sclk = 1'b0;
            sdi = tx[i];
            #400;
            sclk = 1'b1;
            #400;
            rx[i] = sdo_line;
        end
    endtask

    // Deselect, toggle data, park the clock only once deselected
    task automatic close_frame();
        #400;
        cs_n = 1'b1;
        sdi = ~sdi;
        #400;
        sclk = 1'b0;
        #800;
    endtask
endmodule
`default_nettype wire

// ===== testbench/testbench.sv
// Self-checking bench for the serial register port
`timescale 1ns/1ps
`default_nettype none
module testbench
    import srm_pkg::*;
;
    // ----
    // Signals and clock
    // ----
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic sclk, sdi, cs_n, spi_sdo, spi_sdo_oe, rx_byte_ready;
    logic power_down_pin = 1'b0;
    logic [7:0] rx_byte = 8'h00;
    logic rx_byte_valid = 1'b0;
    logic rx_bit = 1'b0;
    logic irq_n_in = 1'b1;
    logic ant_sel = 1'b0;
    logic [2:0] gpio_out, gpio_oe;
    logic [6:0] blk_en;
    srm_mode_t mode;
    wire logic sdo_line;
    int n_errors = 0;
    int n_compared = 0;
    int cycles = 0;

    always #50 sys_clk = ~sys_clk;
    // Pull-up on the released output line
    assign sdo_line = spi_sdo_oe ? spi_sdo : 1'b1;

    srm_spi_dev #(.POR_CYC(300)) dut (.sys_clk(sys_clk), .nrst(nrst),
        .spi_sclk(sclk), .spi_sdi(sdi), .chip_select_n(cs_n),
        .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe),
        .power_down_pin(power_down_pin), .rx_byte(rx_byte),
        .rx_byte_valid(rx_byte_valid), .rx_byte_ready(rx_byte_ready),
        .rx_bit(rx_bit), .irq_n_in(irq_n_in), .ant_sel(ant_sel),
        .gpio_out(gpio_out), .gpio_oe(gpio_oe), .blk_en(blk_en),
        .mode(mode));
    srm_host host (.sclk(sclk), .sdi(sdi), .cs_n(cs_n),
        .sdo_line(sdo_line));

    // ----
    // Shared tasks
    // ----
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %h not %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] r;
        host.open_frame();
        host.shift({1'b1, a}, 8, r);
        host.shift(d, 8, r);
        host.close_frame();
    endtask

    // Read with junk on input; check byte, held last bit, release
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        logic [7:0] r;
        host.open_frame();
        host.shift({1'b0, a}, 8, r);
        host.shift(8'h5A, 8, r);
        #400;
        chk(r, e);
        chk({7'h00, sdo_line}, {7'h00, e[0]});
        host.close_frame();
        chk({7'h00, spi_sdo_oe}, 8'h00);
    endtask

    task automatic conclude();
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ----
    // Scenarios
    // ----
    task automatic t_rw();
        chk({5'h00, mode}, {5'h00, MODE_READY});
        chk({1'b0, blk_en}, 8'h13);
        wr(7'h20, 8'hA5);
        rd(7'h20, 8'hA5);
        rd(7'h20, 8'hA5);
        wr(7'h7E, 8'h3C);
        rd(7'h7E, 8'h3C);
    endtask

    task automatic t_burst();
        logic [7:0] r;
        host.open_frame();
        host.shift(8'hB0, 8, r);
        for (int i = 0; i < 3; i++) host.shift(8'hC0 + 8'(i), 8, r);
        host.close_frame();
        host.open_frame();
        host.shift(8'h30, 8, r);
        for (int i = 0; i < 3; i++) begin
            host.shift(8'h00, 8, r);
            chk(r, 8'hC0 + 8'(i));
        end
        host.close_frame();
    endtask

    task automatic t_partial();
        logic [7:0] r;
        host.open_frame();
        host.shift(8'hFF, 5, r);
        host.close_frame();
        wr(7'h21, 8'h66);
        rd(7'h21, 8'h66);
    endtask

    task automatic t_modes();
        logic [7:0] mb [6] = '{8'h00, 8'h10, 8'h08, 8'h01, 8'h02, 8'h04};
        logic [7:0] en [6] = '{8'h03, 8'h07, 8'h0B, 8'h13, 8'h33, 8'h73};
        for (int i = 0; i < 6; i++) begin
            wr(REG_MODE, mb[i]);
            chk({5'h00, mode}, 8'(i));
            chk({1'b0, blk_en}, en[i]);
        end
        wr(REG_OPT, 8'h03);
        chk({1'b0, blk_en}, 8'h7F);
        wr(REG_MODE, 8'h00);
        chk({1'b0, blk_en}, 8'h03);
        rd(7'h20, 8'hA5);
        rd(REG_OPT, 8'h03);
    endtask

    task automatic t_pins();
        logic [7:0] r;
        host.open_frame();
        host.shift({1'b1, REG_GPIO0}, 8, r);
        host.shift(8'h02, 8, r);
        host.shift(8'h05, 8, r);
        host.shift(8'h06, 8, r);
        host.close_frame();
        ant_sel = 1'b1;
        irq_n_in = 1'b0;
        rx_bit = 1'b1;
        repeat (4) @(negedge sys_clk);
        chk({5'h00, gpio_out}, 8'h05);
        chk({5'h00, gpio_oe}, 8'h07);
        ant_sel = 1'b0;
        irq_n_in = 1'b1;
        rx_bit = 1'b0;
        repeat (4) @(negedge sys_clk);
        chk({5'h00, gpio_out}, 8'h02);
        wr(REG_GPIO0, 8'h01);
        wr(REG_GPIO1, 8'h07);
        wr(REG_GPIO2, 8'h03);
        r = {5'h00, gpio_out};
        repeat (5) @(negedge sys_clk);
        chk({5'h00, gpio_out}, r ^ 8'h01);
        chk({6'h00, gpio_out[2:1]}, 8'h02);
    endtask

    task automatic t_fifo();
        for (int i = 0; i < 64; i++) begin
            @(negedge sys_clk);
            rx_byte = 8'h40 + 8'(i);
            rx_byte_valid = 1'b1;
        end
        @(negedge sys_clk);
        rx_byte = 8'hEE;
        chk({7'h00, rx_byte_ready}, 8'h00);
        chk({7'h00, gpio_out[1]}, 8'h01);
        repeat (3) @(negedge sys_clk);
        rx_byte_valid = 1'b0;
        rd(REG_STATUS, 8'h80);
        wr(REG_FIFO, 8'h11);
        for (int i = 0; i < 64; i++) rd(REG_FIFO, 8'h40 + 8'(i));
        rd(REG_FIFO, 8'h00);
        chk({7'h00, gpio_out[1]}, 8'h00);
    endtask

    task automatic t_shutdown();
        @(negedge sys_clk);
        power_down_pin = 1'b1;
        repeat (5) @(negedge sys_clk);
        chk({1'b0, blk_en}, 8'h00);
        power_down_pin = 1'b0;
        repeat (8) @(negedge sys_clk);
        chk({5'h00, mode}, {5'h00, MODE_READY});
        wr(REG_GPIO2, 8'h04);
        chk({7'h00, gpio_out[2]}, 8'h01);
        chk({5'h00, gpio_oe}, 8'h04);
        repeat (300) @(negedge sys_clk);
        chk({7'h00, gpio_out[2]}, 8'h00);
        rd(7'h20, 8'h00);
    endtask

    // Cycle ceiling against a hang
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 40000) begin
            n_errors++;
            conclude();
        end
    end

    // Main sequence
    initial begin
        repeat (3) @(negedge sys_clk);
        nrst = 1'b1;
        repeat (10) @(negedge sys_clk);
        chk({7'h00, sdo_line}, 8'h01);
        t_rw();
        t_burst();
        t_partial();
        t_modes();
        t_pins();
        t_fifo();
        t_shutdown();
        conclude();
    end
endmodule
`default_nettype wire
